// ===== rtl/dcbf_top.sv
// Purpose: Two opposite queues with mailboxes between a left and a right port
// Assumes: Port clocks are at most a quarter of pclk, high and low two pclk each
// Notes: All port pins pass two pclk flip-flops; port edges are detected on pclk
//
// Overview of operation
// - Reset clears pointers, sets flags to start values
// - Room flags rise two own-port edges after reset
// - Offset picks load threshold on third pclk after reset release
// - Bus drives only with select and direction low
// - Qualified left write stores into rightward queue
// - Qualified left read loads leftward output register
// - Qualified right write stores into leftward queue
// - Qualified right read loads rightward output register
// - Queue flags pass two stages on their port clock
// - Reads ignored while empty; read pointer advances
// - Narrow reads keep flag until last slice read
// - Avail flag rises second reader edge after write
// - Counting starts on first edge after the event
// - Writes ignored while full; write pointer advances
// - Room flag rises second writer edge after read
// - Low-level flag tracks offset, two reader edges
// - High-level flag tracks depth minus offset
// - Mailbox writes selected by pick or width pins
// - Mailbox write drops flag; further writes ignored
// - Left bus shows queue register or leftward mailbox
// - Right bus shows rightward output register or rightward mailbox
// - Right mailbox read raises rightward mail flag
// - Left mailbox read raises leftward mail flag
// - Mailbox contents change only on accepted write
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
`include "dcbf_map.svh"
module dcbf_top
	import dcbf_pkg::*;
#(
	parameter int DEPTH = `DCBF_DEPTH,
	parameter int WIDTH = `DCBF_WIDTH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic offset_pick_0,
	input wire logic offset_pick_1,
	input wire logic left_clock,
	input wire logic left_select_n,
	input wire logic left_direction,
	input wire logic left_strobe,
	input wire logic left_mail_pick,
	input wire logic [WIDTH-1:0] left_bus_in,
	output logic [WIDTH-1:0] left_bus_out,
	output logic left_bus_oe,
	input wire logic right_clock,
	input wire logic right_select_n,
	input wire logic right_direction,
	input wire logic right_strobe,
	input wire logic right_width_sel_lo,
	input wire logic right_width_sel_hi,
	input wire logic [WIDTH-1:0] right_bus_in,
	output logic [WIDTH-1:0] right_bus_out,
	output logic right_bus_oe,
	output logic left_room_flag,
	output logic left_avail_flag,
	output logic left_low_level_flag,
	output logic left_high_level_flag,
	output logic right_room_flag,
	output logic right_avail_flag,
	output logic right_low_level_flag,
	output logic right_high_level_flag,
	output logic rightward_mail_flag,
	output logic leftward_mail_flag
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = WIDTH + 5;
	localparam int RW = WIDTH + 6;
	localparam int Q = WIDTH / 4;

	generate
		if ((WIDTH % 4 != 0) || (AW > 6))
		begin : g_bad_size
			$error("dcbf_top: WIDTH must split in four bytes and DEPTH fit 7 level bits");
		end
	endgenerate

	// Pin synchronisers
	logic [LW-1:0] l_s1_ff, l_s2_ff;
	logic [RW-1:0] r_s1_ff, r_s2_ff;
	logic [1:0] pick_s1_ff, pick_s2_ff;
	logic l_clk_d_ff, r_clk_d_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			l_s1_ff <= '0;
			l_s2_ff <= '0;
			r_s1_ff <= '0;
			r_s2_ff <= '0;
			pick_s1_ff <= '0;
			pick_s2_ff <= '0;
			l_clk_d_ff <= 1'h0;
			r_clk_d_ff <= 1'h0;
		end
		else
		begin
			l_s1_ff <= {left_clock, left_select_n, left_direction, left_strobe, left_mail_pick, left_bus_in};
			l_s2_ff <= l_s1_ff;
			r_s1_ff <= {right_clock, right_select_n, right_direction, right_strobe,
				right_width_sel_hi, right_width_sel_lo, right_bus_in};
			r_s2_ff <= r_s1_ff;
			pick_s1_ff <= {offset_pick_1, offset_pick_0};
			pick_s2_ff <= pick_s1_ff;
			l_clk_d_ff <= l_s2_ff[LW-1];
			r_clk_d_ff <= r_s2_ff[RW-1];
		end
	end

	logic l_sel_n, l_dir, l_strb, l_pick;
	logic r_sel_n, r_dir, r_strb;
	logic [WIDTH-1:0] l_data, r_data;
	dcbf_width_e r_mode;

	assign l_sel_n = l_s2_ff[LW-2];
	assign l_dir = l_s2_ff[LW-3];
	assign l_strb = l_s2_ff[LW-4];
	assign l_pick = l_s2_ff[LW-5];
	assign l_data = l_s2_ff[WIDTH-1:0];
	assign r_sel_n = r_s2_ff[RW-2];
	assign r_dir = r_s2_ff[RW-3];
	assign r_strb = r_s2_ff[RW-4];
	assign r_mode = dcbf_width_e'(r_s2_ff[RW-5:RW-6]);
	assign r_data = r_s2_ff[WIDTH-1:0];

	// Start-up: wait for the offset picks to pass the synchroniser, then load
	dcbf_boot_e boot_ff, nxt_boot;
	dcbf_ofs_t offset_ff;
	logic ctrl_en_ff;
	logic ports_on;

	always_comb
	begin
		case (boot_ff)
			DCBF_B_SYNC0: nxt_boot = DCBF_B_SYNC1;
			DCBF_B_SYNC1: nxt_boot = DCBF_B_LOAD;
			DCBF_B_LOAD: nxt_boot = DCBF_B_RUN;
			default: nxt_boot = DCBF_B_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			boot_ff <= DCBF_B_SYNC0;
			offset_ff <= `DCBF_OFS_LL;
		end
		else
		begin
			boot_ff <= nxt_boot;
			if (boot_ff == DCBF_B_LOAD)
			begin
				case (pick_s2_ff)
					2'b11: offset_ff <= `DCBF_OFS_HH;
					2'b10: offset_ff <= `DCBF_OFS_HL;
					2'b01: offset_ff <= `DCBF_OFS_LH;
					default: offset_ff <= `DCBF_OFS_LL;
				endcase
			end
		end
	end

	assign ports_on = (boot_ff == DCBF_B_RUN) & ctrl_en_ff;

	// Port edge and request decode
	logic l_edge, r_edge, l_wr, l_rd, r_wr, r_rd, r_mail;
	logic l_push, l_pop, l_mail_wr, l_mail_rd;
	logic r_push, r_rd_q, r_pop, r_mail_wr, r_mail_rd;

	assign l_edge = l_s2_ff[LW-1] & ~l_clk_d_ff & ports_on;
	assign r_edge = r_s2_ff[RW-1] & ~r_clk_d_ff & ports_on;
	assign l_wr = l_edge & ~l_sel_n & l_dir & l_strb;
	assign l_rd = l_edge & ~l_sel_n & ~l_dir & l_strb;
	assign r_wr = r_edge & ~r_sel_n & r_dir & r_strb;
	assign r_rd = r_edge & ~r_sel_n & ~r_dir & r_strb;
	assign r_mail = (r_mode == DCBF_W_MAIL);

	assign l_push = l_wr & ~l_pick & left_room_flag;
	assign l_pop = l_rd & ~l_pick & left_avail_flag;
	assign l_mail_wr = l_wr & l_pick & rightward_mail_flag;
	assign l_mail_rd = l_rd & l_pick;
	assign r_push = r_wr & ~r_mail & right_room_flag;
	assign r_rd_q = r_rd & ~r_mail & right_avail_flag;
	assign r_mail_wr = r_wr & r_mail & leftward_mail_flag;
	assign r_mail_rd = r_rd & r_mail;

	// Narrow right reads: one word popped, its slices shifted out low first
	logic [1:0] slice_ff, nxt_slice;
	dcbf_width_e last_mode_ff, nxt_mode;
	logic [WIDTH-1:0] shift_ff, nxt_shift;
	logic r_keep, r_hold_next;
	logic [WIDTH-1:0] rq_head, lq_head;
	logic [AW:0] rq_level, lq_level;

	// A new width drops any unread slices of the previous word
	assign r_keep = (slice_ff != 2'h0) && (r_mode == last_mode_ff);
	assign r_pop = r_rd_q & ~r_keep;

	always_comb
	begin
		nxt_slice = slice_ff;
		nxt_shift = shift_ff;
		nxt_mode = last_mode_ff;
		if (r_rd_q)
		begin
			nxt_mode = r_mode;
			if (r_keep)
			begin
				nxt_slice = slice_ff - 2'h1;
				nxt_shift = (r_mode == DCBF_W_BYTE) ? (shift_ff >> Q) : (shift_ff >> (2 * Q));
			end
			else
			begin
				nxt_shift = rq_head;
				case (r_mode)
					DCBF_W_HALF: nxt_slice = 2'h1;
					DCBF_W_BYTE: nxt_slice = 2'h3;
					default: nxt_slice = 2'h0;
				endcase
			end
		end
	end

	assign r_hold_next = (nxt_slice != 2'h0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slice_ff <= 2'h0;
			shift_ff <= '0;
			last_mode_ff <= DCBF_W_LONG;
		end
		else
		begin
			slice_ff <= nxt_slice;
			shift_ff <= nxt_shift;
			last_mode_ff <= nxt_mode;
		end
	end

	dcbf_queue #(
		.DEPTH(DEPTH),
		.WIDTH(WIDTH)
	) u_rightward_queue (
		.pclk(pclk),
		.presetn(presetn),
		.offset(offset_ff),
		.wr_edge(l_edge),
		.wr_push(l_push),
		.wr_data(l_data),
		.rd_edge(r_edge),
		.rd_pop(r_pop),
		.rd_hold_next(r_hold_next),
		.room_flag(left_room_flag),
		.high_flag(left_high_level_flag),
		.avail_flag(right_avail_flag),
		.low_flag(right_low_level_flag),
		.head(rq_head),
		.level(rq_level)
	);

	dcbf_queue #(
		.DEPTH(DEPTH),
		.WIDTH(WIDTH)
	) u_leftward_queue (
		.pclk(pclk),
		.presetn(presetn),
		.offset(offset_ff),
		.wr_edge(r_edge),
		.wr_push(r_push),
		.wr_data(r_data),
		.rd_edge(l_edge),
		.rd_pop(l_pop),
		.rd_hold_next(1'b0),
		.room_flag(right_room_flag),
		.high_flag(right_high_level_flag),
		.avail_flag(left_avail_flag),
		.low_flag(left_low_level_flag),
		.head(lq_head),
		.level(lq_level)
	);

	// Left output register of the leftward queue
	logic [WIDTH-1:0] l_out_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			l_out_ff <= '0;
		else if (l_pop)
			l_out_ff <= lq_head;
	end

	// Mailboxes; a write wins over a read of the same mailbox in one cycle
	logic [WIDTH-1:0] rmail_ff, lmail_ff;
	logic rmail_flag_ff, lmail_flag_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rmail_ff <= '0;
			rmail_flag_ff <= `DCBF_MAIL_RST;
		end
		else if (l_mail_wr)
		begin
			rmail_ff <= l_data;
			rmail_flag_ff <= 1'h0;
		end
		else if (r_mail_rd)
			rmail_flag_ff <= 1'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lmail_ff <= '0;
			lmail_flag_ff <= `DCBF_MAIL_RST;
		end
		else if (r_mail_wr)
		begin
			lmail_ff <= r_data;
			lmail_flag_ff <= 1'h0;
		end
		else if (l_mail_rd)
			lmail_flag_ff <= 1'h1;
	end

	assign rightward_mail_flag = rmail_flag_ff;
	assign leftward_mail_flag = lmail_flag_ff;

	// Bus drivers
	logic [WIDTH-1:0] l_bus_ff, r_bus_ff;
	logic l_oe_ff, r_oe_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			l_bus_ff <= '0;
			r_bus_ff <= '0;
			l_oe_ff <= 1'h0;
			r_oe_ff <= 1'h0;
		end
		else
		begin
			l_oe_ff <= ~l_sel_n & ~l_dir;
			r_oe_ff <= ~r_sel_n & ~r_dir;
			l_bus_ff <= l_pick ? lmail_ff : l_out_ff;
			r_bus_ff <= r_mail ? rmail_ff : shift_ff;
		end
	end

	assign left_bus_out = l_bus_ff;
	assign left_bus_oe = l_oe_ff;
	assign right_bus_out = r_bus_ff;
	assign right_bus_oe = r_oe_ff;

	// APB slave: answer in the first access cycle, no wait states
	logic [31:0] rd_val;
	logic known;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;

	always_comb
	begin
		rd_val = 32'h0;
		known = 1'b1;
		if (paddr == `DCBF_ADDR_CTRL)
			rd_val[`DCBF_CTRL_EN_POS] = ctrl_en_ff;
		else if (paddr == `DCBF_ADDR_STATUS)
			rd_val = {21'h0, (boot_ff == DCBF_B_RUN), lmail_flag_ff, rmail_flag_ff,
				right_high_level_flag, right_low_level_flag, right_avail_flag, right_room_flag,
				left_high_level_flag, left_low_level_flag, left_avail_flag, left_room_flag};
		else if (paddr == `DCBF_ADDR_LEVEL)
		begin
			rd_val[`DCBF_LVL_POS_R +: 7] = 7'(rq_level);
			rd_val[`DCBF_LVL_POS_L +: 7] = 7'(lq_level);
			rd_val[`DCBF_LVL_POS_OFS +: 5] = offset_ff;
		end
		else
			known = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'h0;
			pslverr_ff <= 1'h0;
			prdata_ff <= 32'h0;
		end
		else
		begin
			pready_ff <= psel & ~penable;
			if (psel & ~penable)
			begin
				pslverr_ff <= ~known;
				prdata_ff <= pwrite ? 32'h0 : rd_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_en_ff <= `DCBF_CTRL_RST;
		else if (psel & penable & pready_ff & pwrite & (paddr == `DCBF_ADDR_CTRL))
			ctrl_en_ff <= pwdata[`DCBF_CTRL_EN_POS];
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
endmodule : dcbf_top

// ===== rtl/dcbf_map.svh
// Purpose: Constants for the two-way queue block with mailboxes
// Assumes: Included by bare name after the timescale line
// Notes: Offsets are byte addresses on APB
`ifndef DCBF_MAP_SVH
`define DCBF_MAP_SVH
`define DCBF_DEPTH 64
`define DCBF_WIDTH 36
`define DCBF_ADDR_CTRL 12'h000
`define DCBF_ADDR_STATUS 12'h004
`define DCBF_ADDR_LEVEL 12'h008
`define DCBF_CTRL_RST 1'h1
`define DCBF_CTRL_EN_POS 0
`define DCBF_OFS_HH 5'h10
`define DCBF_OFS_HL 5'h0c
`define DCBF_OFS_LH 5'h08
`define DCBF_OFS_LL 5'h04
`define DCBF_MAIL_RST 1'h1
`define DCBF_ROOM_RST 1'h0
`define DCBF_AVAIL_RST 1'h0
`define DCBF_LOW_RST 1'h0
`define DCBF_HIGH_RST 1'h1
`define DCBF_LVL_POS_R 0
`define DCBF_LVL_POS_L 8
`define DCBF_LVL_POS_OFS 16
`endif

// ===== rtl/dcbf_pkg.sv
// Purpose: Types shared by the two-way queue block
// Assumes: Nothing
// Notes: Width codes follow the two right width-select pins, high pin first
package dcbf_pkg;
	typedef enum logic [1:0] {
		DCBF_W_LONG = 2'b00,
		DCBF_W_HALF = 2'b01,
		DCBF_W_BYTE = 2'b10,
		DCBF_W_MAIL = 2'b11
	} dcbf_width_e;
	typedef enum logic [1:0] {
		DCBF_B_SYNC0 = 2'b00,
		DCBF_B_SYNC1 = 2'b01,
		DCBF_B_LOAD = 2'b10,
		DCBF_B_RUN = 2'b11
	} dcbf_boot_e;
	typedef logic [4:0] dcbf_ofs_t;
endpackage : dcbf_pkg

// ===== rtl/dcbf_queue.sv
// Purpose: One queue with its writer-side and reader-side level flags
// Assumes: Caller qualifies push and pop with the flags it reads back
// Notes: Flags turn bad at once on the own port, good after two port edges
`timescale 1ns/100ps
`include "dcbf_map.svh"
module dcbf_queue
	import dcbf_pkg::*;
#(
	parameter int DEPTH = `DCBF_DEPTH,
	parameter int WIDTH = `DCBF_WIDTH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire dcbf_ofs_t offset,
	input wire logic wr_edge,
	input wire logic wr_push,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_edge,
	input wire logic rd_pop,
	input wire logic rd_hold_next,
	output logic room_flag,
	output logic high_flag,
	output logic avail_flag,
	output logic low_flag,
	output logic [WIDTH-1:0] head,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW+1:0] FULL_W = (AW+2)'(DEPTH);

	generate
		if ((DEPTH != (1 << AW)) || (DEPTH < 32))
		begin : g_bad_depth
			$error("dcbf_queue: DEPTH must be a power of two of at least 32");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_ff;
	logic [AW-1:0] rptr_ff;
	logic [AW:0] level_ff;
	logic do_push;
	logic do_pop;
	logic [AW+1:0] x_w;
	logic [AW+1:0] lvl_up;
	logic [AW+1:0] lvl_dn;
	logic room_s_ff, high_s_ff, avail_s_ff, low_s_ff;
	logic room_ff, high_ff, avail_ff, low_ff;

	assign do_push = wr_push & (level_ff != FULL_W[AW:0]);
	assign do_pop = rd_pop & (level_ff != '0);
	assign x_w = (AW+2)'(offset);
	assign lvl_up = (AW+2)'(level_ff) + (AW+2)'(do_push);
	assign lvl_dn = (AW+2)'(level_ff) - (AW+2)'(do_pop);

	always_ff @(posedge pclk)
	begin
		if (do_push)
			mem[wptr_ff] <= wr_data;
	end

	// Pointers and fill level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			level_ff <= '0;
		end
		else
		begin
			wptr_ff <= wptr_ff + AW'(do_push);
			rptr_ff <= rptr_ff + AW'(do_pop);
			level_ff <= level_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// Writer-side flags step only on writer port edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			room_s_ff <= `DCBF_ROOM_RST;
			room_ff <= `DCBF_ROOM_RST;
			high_s_ff <= `DCBF_HIGH_RST;
			high_ff <= `DCBF_HIGH_RST;
		end
		else if (wr_edge)
		begin
			room_s_ff <= (lvl_up < FULL_W);
			room_ff <= room_s_ff & (lvl_up < FULL_W);
			high_s_ff <= (lvl_up < FULL_W - x_w);
			high_ff <= high_s_ff & (lvl_up < FULL_W - x_w);
		end
	end

	// Reader-side flags step only on reader port edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			avail_s_ff <= `DCBF_AVAIL_RST;
			avail_ff <= `DCBF_AVAIL_RST;
			low_s_ff <= `DCBF_LOW_RST;
			low_ff <= `DCBF_LOW_RST;
		end
		else if (rd_edge)
		begin
			avail_s_ff <= (lvl_dn != '0) | rd_hold_next;
			avail_ff <= avail_s_ff & ((lvl_dn != '0) | rd_hold_next);
			low_s_ff <= (lvl_dn > x_w);
			low_ff <= low_s_ff & (lvl_dn > x_w);
		end
	end

	assign room_flag = room_ff;
	assign high_flag = high_ff;
	assign avail_flag = avail_ff;
	assign low_flag = low_ff;
	assign head = mem[rptr_ff];
	assign level = level_ff;
endmodule : dcbf_queue

// ===== verification/dcbf_props.sv
// Purpose: Port-side timing checks for the two-way queue block
// Assumes: Port pins act three pclk edges after they are sampled
// Notes: Flag changes are traced back to the pins seen three edges earlier
`timescale 1ns/100ps
module dcbf_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic left_clock,
	input wire logic left_select_n,
	input wire logic left_direction,
	input wire logic left_strobe,
	input wire logic left_mail_pick,
	input wire logic left_bus_oe,
	input wire logic left_room_flag,
	input wire logic leftward_mail_flag,
	input wire logic right_clock,
	input wire logic right_select_n,
	input wire logic right_direction,
	input wire logic right_strobe,
	input wire logic right_width_sel_lo,
	input wire logic right_width_sel_hi,
	input wire logic right_bus_oe,
	input wire logic right_avail_flag,
	input wire logic rightward_mail_flag
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	left_hiz_a: assert property ((left_select_n | left_direction) [*3] |=> !left_bus_oe)
		else $error("left bus driven while deselected");
	right_hiz_a: assert property ((right_select_n | right_direction) [*3] |=> !right_bus_oe)
		else $error("right bus driven while deselected");
	rmail_take_a: assert property ($fell(rightward_mail_flag) |-> $past(left_mail_pick & left_direction & left_strobe & !left_select_n, 3))
		else $error("rightward mail flag fell without a left mail write");
	lmail_take_a: assert property ($fell(leftward_mail_flag) |-> $past(right_width_sel_hi & right_width_sel_lo & right_direction & right_strobe & !right_select_n, 3))
		else $error("leftward mail flag fell without a right mail write");
	lmail_free_a: assert property ($rose(leftward_mail_flag) |-> $past(left_mail_pick & !left_direction & left_strobe & !left_select_n, 3))
		else $error("leftward mail flag rose without a left mail read");
	rmail_free_a: assert property ($rose(rightward_mail_flag) |-> $past(right_width_sel_hi & right_width_sel_lo & !right_direction & !right_select_n, 3))
		else $error("rightward mail flag rose without a right mail read");
	lroom_drop_a: assert property ($fell(left_room_flag) |-> $past(left_direction & left_strobe & !left_select_n & !left_mail_pick, 3))
		else $error("left room flag fell without a left write");
	ravail_drop_a: assert property ($fell(right_avail_flag) |-> $past(!right_direction & right_strobe & !right_select_n, 3))
		else $error("right avail flag fell without a right read");
	lroom_rise_a: assert property ($rose(left_room_flag) |-> $past(left_clock, 3))
		else $error("left room flag rose away from a left clock rise");
	ravail_rise_a: assert property ($rose(right_avail_flag) |-> $past(right_clock, 3))
		else $error("right avail flag rose away from a right clock rise");
endmodule : dcbf_props

// ===== verification/dcbf_port_model.sv
// Purpose: Processor-side model of one queue port
// Assumes: pclk runs at least eight times the port clock
// Notes: Port clock stands low between operations; released data toggles
`timescale 1ns/100ps
module dcbf_port_model
(
	input wire logic pclk,
	output logic port_clk,
	output logic sel_n,
	output logic dir,
	output logic stb,
	output logic [1:0] mode,
	output logic [35:0] data
);
	initial
	begin
		port_clk = 1'h0;
		sel_n = 1'h1;
		dir = 1'h0;
		stb = 1'h0;
		mode = 2'h0;
		data = 36'h0;
	end
	task automatic op(input logic s, input logic d, input logic e, input logic [1:0] m, input logic [35:0] v);
		@(posedge pclk);
		sel_n <= s;
		dir <= d;
		stb <= e;
		mode <= m;
		data <= d ? v : ~data;
		// Rise waits until a bus the block drove has turned round to our data
		repeat (5) @(posedge pclk);
		port_clk <= 1'h1;
		repeat (4) @(posedge pclk);
		port_clk <= 1'h0;
		repeat (3) @(posedge pclk);
		stb <= 1'h0;
		data <= ~data;
	endtask : op
endmodule : dcbf_port_model

// ===== verification/dcbf_top_tb.sv
// Purpose: Self-checking bench for the two-way queue block
// Assumes: One port model on each side paces its port clock from pclk
// Notes: Checker is bound at the foot of this file
`timescale 1ns/100ps
`include "dcbf_map.svh"
module dcbf_top_tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic offset_pick_0 = 1'h0;
	logic offset_pick_1 = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, left_clock, left_select_n, left_direction, left_strobe, left_mail_pick;
	logic left_bus_oe, right_clock, right_select_n, right_direction, right_strobe, right_bus_oe;
	logic right_width_sel_lo, right_width_sel_hi, rightward_mail_flag, leftward_mail_flag;
	logic left_room_flag, left_avail_flag, left_low_level_flag, left_high_level_flag;
	logic right_room_flag, right_avail_flag, right_low_level_flag, right_high_level_flag;
	logic [35:0] left_bus_in, left_bus_out, right_bus_in, right_bus_out, ldata, rdata;
	logic [1:0] lmode, rmode;
	int fail_count = 0;
	int tests_run = 0;
	assign left_mail_pick = lmode[0];
	assign {right_width_sel_hi, right_width_sel_lo} = rmode;
	assign left_bus_in = left_bus_oe ? left_bus_out : ldata;
	assign right_bus_in = right_bus_oe ? right_bus_out : rdata;
	dcbf_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.offset_pick_0, .offset_pick_1, .left_clock, .left_select_n, .left_direction, .left_strobe,
		.left_mail_pick, .left_bus_in, .left_bus_out, .left_bus_oe, .right_clock, .right_select_n,
		.right_direction, .right_strobe, .right_width_sel_lo, .right_width_sel_hi, .right_bus_in,
		.right_bus_out, .right_bus_oe, .left_room_flag, .left_avail_flag, .left_low_level_flag,
		.left_high_level_flag, .right_room_flag, .right_avail_flag, .right_low_level_flag,
		.right_high_level_flag, .rightward_mail_flag, .leftward_mail_flag);
	dcbf_port_model i_lm (.pclk(pclk), .port_clk(left_clock), .sel_n(left_select_n), .dir(left_direction),
		.stb(left_strobe), .mode(lmode), .data(ldata));
	dcbf_port_model i_rm (.pclk(pclk), .port_clk(right_clock), .sel_n(right_select_n), .dir(right_direction),
		.stb(right_strobe), .mode(rmode), .data(rdata));
	initial
		forever #5 pclk = ~pclk;
	task automatic end_sim;
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	function automatic logic [35:0] pat(input int i);
		return 36'h9a5a50000 + 36'(i);
	endfunction : pat
	task automatic idle_both;
		fork
			i_lm.op(1'h1, 1'h0, 1'h0, 2'h0, 36'h0);
			i_rm.op(1'h1, 1'h0, 1'h0, 2'h0, 36'h0);
		join
	endtask : idle_both
	task automatic reset_dut(input logic [1:0] fs);
		presetn <= 1'h0;
		offset_pick_1 <= fs[1];
		offset_pick_0 <= fs[0];
		repeat (4) idle_both();
		chk({left_room_flag, right_room_flag, left_avail_flag, right_avail_flag, left_low_level_flag,
			right_low_level_flag, left_high_level_flag, right_high_level_flag, rightward_mail_flag,
			leftward_mail_flag}, 36'hf);
		presetn <= 1'h1;
		repeat (6) @(posedge pclk);
		apb(1'h0, `DCBF_ADDR_LEVEL, 32'h0);
		chk(36'(rd[20:16]), 36'(4 * (fs + 1)));
		idle_both();
		chk({left_room_flag, right_room_flag}, 36'h0);
		idle_both();
		chk({left_room_flag, right_room_flag}, 36'h3);
	endtask : reset_dut
	task automatic t_fill_drain;
		for (int i = 0; i < 65; i++)
		begin
			i_lm.op(1'h0, 1'h1, 1'h1, 2'h0, pat(i));
			chk(left_high_level_flag, 36'(i < 47));
			chk(left_room_flag, 36'(i < 63));
		end
		apb(1'h0, `DCBF_ADDR_LEVEL, 32'h0);
		chk(36'(rd[6:0]), 36'h40);
		i_rm.op(1'h0, 1'h0, 1'h0, 2'h0, 36'h0);
		chk(right_avail_flag, 36'h0);
		i_rm.op(1'h0, 1'h0, 1'h0, 2'h0, 36'h0);
		chk({right_avail_flag, right_low_level_flag}, 36'h3);
		for (int i = 0; i < 65; i++)
		begin
			i_rm.op(1'h0, 1'h0, 1'h1, 2'h0, 36'h0);
			chk(right_bus_out, pat(i < 64 ? i : 63));
			chk(right_low_level_flag, 36'(i < 47));
			chk(right_avail_flag, 36'(i < 63));
			if (i == 0 || i == 16)
			begin
				i_lm.op(1'h1, 1'h0, 1'h0, 2'h0, 36'h0);
				chk({left_room_flag, left_high_level_flag}, (i == 16) ? 36'h2 : 36'h0);
				i_lm.op(1'h1, 1'h0, 1'h0, 2'h0, 36'h0);
				chk({left_room_flag, left_high_level_flag}, (i == 16) ? 36'h3 : 36'h2);
			end
		end
	endtask : t_fill_drain
	task automatic t_narrow;
		for (int w = 1; w < 3; w++)
		begin
			int s;
			logic [35:0] m;
			s = 18 / w;
			m = (36'h1 << s) - 36'h1;
			i_lm.op(1'h0, 1'h1, 1'h1, 2'h0, pat(100 + w));
			repeat (2) i_rm.op(1'h0, 1'h0, 1'h0, 2'(w), 36'h0);
			for (int k = 0; k < 2 * w; k++)
			begin
				i_rm.op(1'h0, 1'h0, 1'h1, 2'(w), 36'h0);
				chk(right_bus_out & m, (pat(100 + w) >> (s * k)) & m);
				chk(right_avail_flag, 36'(k < 2 * w - 1));
			end
		end
	endtask : t_narrow
	task automatic t_mail;
		i_lm.op(1'h0, 1'h1, 1'h1, 2'h1, 36'h123456789);
		chk(rightward_mail_flag, 36'h0);
		i_lm.op(1'h0, 1'h1, 1'h1, 2'h1, 36'h0aaaaaaaa);
		repeat (2)
		begin
			i_rm.op(1'h0, 1'h0, 1'h1, 2'h3, 36'h0);
			chk(right_bus_out, 36'h123456789);
			chk(rightward_mail_flag, 36'h1);
		end
		i_rm.op(1'h0, 1'h1, 1'h1, 2'h3, 36'h876543210);
		chk(leftward_mail_flag, 36'h0);
		chk(right_bus_oe, 36'h0);
		i_rm.op(1'h0, 1'h1, 1'h1, 2'h0, 36'h0f0f0f0f0);
		repeat (2) i_lm.op(1'h0, 1'h0, 1'h0, 2'h0, 36'h0);
		i_lm.op(1'h0, 1'h0, 1'h1, 2'h0, 36'h0);
		chk(left_bus_out, 36'h0f0f0f0f0);
		i_lm.op(1'h0, 1'h0, 1'h1, 2'h1, 36'h0);
		chk(left_bus_out, 36'h876543210);
		chk(leftward_mail_flag, 36'h1);
		i_lm.op(1'h0, 1'h0, 1'h1, 2'h0, 36'h0);
		chk(left_bus_out, 36'h0f0f0f0f0);
		chk(left_bus_oe, 36'h1);
		apb(1'h0, 12'hffc, 32'h0);
		chk(err, 36'h1);
		// Ports frozen: a left mail write must leave the rightward flag high
		@(posedge pclk);
		apb(1'h1, `DCBF_ADDR_CTRL, 32'h0);
		i_lm.op(1'h0, 1'h1, 1'h1, 2'h1, 36'h0);
		apb(1'h0, `DCBF_ADDR_STATUS, 32'h0);
		chk(36'(rd[10:8]), 36'h7);
		chk(err, 36'h0);
	endtask : t_mail
	initial
	begin
		@(posedge pclk);
		for (int c = 0; c < 4; c++)
			reset_dut(2'(c));
		t_fill_drain();
		t_narrow();
		t_mail();
		end_sim();
	end
	// The run needs about 2500 pclk; allow eight times that
	initial
	begin
		#200000;
		fail_count++;
		end_sim();
	end
endmodule : dcbf_top_tb
bind dcbf_top dcbf_props i_props (.pclk, .presetn, .left_clock, .left_select_n, .left_direction, .left_strobe,
	.left_mail_pick, .left_bus_oe, .left_room_flag, .leftward_mail_flag, .right_clock, .right_select_n,
	.right_direction, .right_strobe, .right_width_sel_lo, .right_width_sel_hi, .right_bus_oe,
	.right_avail_flag, .rightward_mail_flag);
